// File: keypad_pkg.sv
// package: register map, field positions and reset values of the keypad interrupt unit
package keypad_pkg;

	localparam int LINE_COUNT = 8;

	// ------------------------------------------------------------
	// special function register addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_LINE_LEVEL_SELECT = 8'h9c;
	localparam logic [7:0] ADDR_LINE_INTERRUPT_ENABLE = 8'h9d;
	localparam logic [7:0] ADDR_LINE_DETECT_FLAGS = 8'h9e;
	localparam logic [7:0] ADDR_SECOND_IRQ_ENABLE_REG = 8'hb1;
	localparam logic [7:0] ADDR_PRIORITY_LOW_REG = 8'hb2;
	localparam logic [7:0] ADDR_PRIORITY_HIGH_REG = 8'hb3;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int GLOBAL_ENABLE_BIT = 0;
	localparam int PRIORITY_BIT = 0;
	localparam int SOFT_CLEAR_LINE = 2;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] LINE_REG_RESET = 8'h00;
	localparam logic [7:0] OWN_BIT_MASK = 8'h01;
	// flags cleared by the read: every line except line 2
	localparam logic [7:0] READ_CLEAR_MASK = 8'hfb;

	// register port request, one bus cycle
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_s;

	// state seen by the core
	typedef struct packed {
		logic irq_request;
		logic wake;
		logic [1:0] priority_level;
	} keypad_status_s;

endpackage

// File: line_sync.sv
// two-stage synchroniser for the eight port inputs
`timescale 1ns/1ns
module line_sync #(
	parameter int WIDTH = 8
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage_one;

	// first stage is read only by the second stage
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			// idle level of the pulled-up pins: a zero here would look like a low level
			// on every line and set false flags for two cycles after reset
			stage_one <= '1;
			sync_out <= '1;
		end else begin
			stage_one <= async_in;
			sync_out <= stage_one;
		end
	end
endmodule // line_sync

// File: keypad_level_interrupt.sv
// keypad level interrupt unit: eight level-detect lines on port one, sfr port to the core
// Behaviour
// - eight port lines are separate sources sharing one keypad vector request
// - level select bit 0 detects low, 1 detects high on that line
// - hardware sets flag n while line n shows its programmed level
// - flag n reaches the request only when its line enable bit is set
// - reading the flag register clears flags 0, 1 and 3 to 7
// - enable bit 0 leaves pin n a plain port pin: its flag still sets but reaches neither the request nor wake
// - one global enable gates the combined request to the core
// - lines are port one alternate function and a keypad event wakes the core
// - flag, enable and level select registers reset to all zeros
// - global enable is bit 0 of the second enable register at b1h
// - priority is two bits high and low, 00 lowest, 11 highest
`timescale 1ns/1ns
module keypad_level_interrupt #(
	parameter int LINES = keypad_pkg::LINE_COUNT
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [LINES-1:0] port_one,
	input wire keypad_pkg::sfr_req_s sfr_req,
	output logic [7:0] sfr_rdata,
	output logic sfr_hit,
	output logic [LINES-1:0] keypad_pin_claim,
	output keypad_pkg::keypad_status_s status
);
	import keypad_pkg::*;

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [LINES-1:0] line_level_select;
	logic [LINES-1:0] line_interrupt_enable;
	logic [LINES-1:0] line_detect_flags;
	logic global_keypad_irq_enable;
	logic keypad_priority_low;
	logic keypad_priority_high;

	logic [LINES-1:0] port_sync;

	line_sync #(
		.WIDTH(LINES)
	) u_line_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.async_in(port_one),
		.sync_out(port_sync)
	);

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	function automatic logic hit(input sfr_req_s r, input logic [7:0] a);
		return (r.rd | r.wr) && (r.addr == a);
	endfunction

	wire sel_lvl = hit(sfr_req, ADDR_LINE_LEVEL_SELECT);
	wire sel_en = hit(sfr_req, ADDR_LINE_INTERRUPT_ENABLE);
	wire sel_flg = hit(sfr_req, ADDR_LINE_DETECT_FLAGS);
	wire sel_ie1 = hit(sfr_req, ADDR_SECOND_IRQ_ENABLE_REG);
	wire sel_ipl = hit(sfr_req, ADDR_PRIORITY_LOW_REG);
	wire sel_iph = hit(sfr_req, ADDR_PRIORITY_HIGH_REG);
	wire any_sel = sel_lvl | sel_en | sel_flg | sel_ie1 | sel_ipl | sel_iph;

	// ------------------------------------------------------------
	// detection and flags
	// ------------------------------------------------------------
	// xnor: select 0 matches a low pin, select 1 a high pin
	wire [LINES-1:0] level_match = ~(port_sync ^ line_level_select);
	wire [LINES-1:0] flag_read_clear = (sfr_req.rd && sel_flg) ?
		READ_CLEAR_MASK[LINES-1:0] : '0;
	// software writes of 0 clear flags; line 2 has no other way out
	wire [LINES-1:0] flag_write_clear = (sfr_req.wr && sel_flg) ?
		~sfr_req.wdata[LINES-1:0] : '0;
	// set beats clear so a held key is never lost
	wire [LINES-1:0] next_flags =
		(line_detect_flags & ~flag_read_clear & ~flag_write_clear) | level_match;
	wire [LINES-1:0] masked_flags = line_detect_flags & line_interrupt_enable;
	wire next_request = (|masked_flags) & global_keypad_irq_enable;
	// wake does not wait for the global enable, only for a line owned by the keypad
	wire next_wake = |(level_match & line_interrupt_enable);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			line_detect_flags <= LINE_REG_RESET[LINES-1:0];
		end else begin
			line_detect_flags <= next_flags;
		end
	end

	// ------------------------------------------------------------
	// software registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			line_level_select <= LINE_REG_RESET[LINES-1:0];
			line_interrupt_enable <= LINE_REG_RESET[LINES-1:0];
			global_keypad_irq_enable <= 1'b0;
			keypad_priority_low <= 1'b0;
			keypad_priority_high <= 1'b0;
		end else if (sfr_req.wr) begin
			if (sel_lvl) begin
				line_level_select <= sfr_req.wdata[LINES-1:0];
			end
			if (sel_en) begin
				line_interrupt_enable <= sfr_req.wdata[LINES-1:0];
			end
			if (sel_ie1) begin
				global_keypad_irq_enable <= sfr_req.wdata[GLOBAL_ENABLE_BIT];
			end
			if (sel_ipl) begin
				keypad_priority_low <= sfr_req.wdata[PRIORITY_BIT];
			end
			if (sel_iph) begin
				keypad_priority_high <= sfr_req.wdata[PRIORITY_BIT];
			end
		end
	end

	// ------------------------------------------------------------
	// read data and outputs
	// ------------------------------------------------------------
	// other bits of the shared b1h..b3h registers belong to other units: read 0 here
	wire [7:0] next_rdata =
		sel_lvl ? 8'(line_level_select) :
		sel_en ? 8'(line_interrupt_enable) :
		sel_flg ? 8'(line_detect_flags) :
		sel_ie1 ? {7'h00, global_keypad_irq_enable} :
		sel_ipl ? {7'h00, keypad_priority_low} :
		sel_iph ? {7'h00, keypad_priority_high} : 8'h00;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sfr_rdata <= 8'h00;
			sfr_hit <= 1'b0;
			keypad_pin_claim <= '0;
			status <= '0;
		end else begin
			sfr_rdata <= sfr_req.rd ? next_rdata : 8'h00;
			sfr_hit <= any_sel;
			keypad_pin_claim <= line_interrupt_enable;
			status.irq_request <= next_request;
			status.wake <= next_wake;
			status.priority_level <= {keypad_priority_high, keypad_priority_low};
		end
	end

endmodule // keypad_level_interrupt

// File: keypad_props.sv
// checker on the keypad unit ports
`timescale 1ns/1ns
module keypad_props (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] port_one,
	input wire keypad_pkg::sfr_req_s sfr_req,
	input wire logic [7:0] sfr_rdata,
	input wire logic sfr_hit,
	input wire logic [7:0] keypad_pin_claim,
	input wire keypad_pkg::keypad_status_s status
);
	import keypad_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire [7:0] a = sfr_req.addr;
	wire mapped = a inside {8'h9c, 8'h9d, 8'h9e, 8'hb1, 8'hb2, 8'hb3};
	sequence s_en_wr; sfr_req.wr && a == 8'h9d; endsequence
	sequence s_glob_off; sfr_req.wr && a == 8'hb1 && !sfr_req.wdata[0]; endsequence
	property p_hit; 1 |=> sfr_hit == $past((sfr_req.rd | sfr_req.wr) && mapped); endproperty
	a_hit: assert property (p_hit) else $error("hit");
	property p_claim; s_en_wr |-> ##2 keypad_pin_claim == $past(sfr_req.wdata, 2); endproperty
	a_claim: assert property (p_claim) else $error("claim");
	property p_irq; status.irq_request |-> keypad_pin_claim != 8'h00; endproperty
	a_irq: assert property (p_irq) else $error("irq");
	property p_wake; status.wake |-> keypad_pin_claim != 8'h00; endproperty
	a_wake: assert property (p_wake) else $error("wake");
	property p_glob; s_glob_off |-> ##2 !status.irq_request; endproperty
	a_glob: assert property (p_glob) else $error("glob");
	property p_rst; $fell(rst) |-> !sfr_hit && status == 4'h0; endproperty
	a_rst: assert property (p_rst) else $error("rst");
	property p_rsvd; sfr_req.rd && a[7:4] == 4'hb |=> sfr_rdata[7:1] == 7'h00; endproperty
	a_rsvd: assert property (p_rsvd) else $error("rsvd");
	property p_unmap; sfr_req.rd && !mapped |=> sfr_rdata == 8'h00; endproperty
	a_unmap: assert property (p_unmap) else $error("unmap");
endmodule // keypad_props
bind keypad_level_interrupt keypad_props chk (.ref_clk(ref_clk), .rst(rst), .port_one(port_one),
	.sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
	.keypad_pin_claim(keypad_pin_claim), .status(status));

// File: key_matrix.sv
// key matrix model: a closed key pulls its line low
`timescale 1ns/1ns
module key_matrix (
	input wire logic [7:0] pressed,
	output logic [7:0] port_one
);
	assign port_one = ~pressed;
endmodule // key_matrix

// File: keypad_level_interrupt_bench.sv
// keypad unit bench
`timescale 1ns/1ns
module keypad_level_interrupt_bench;
	import keypad_pkg::*;
	logic ref_clk = 1'b0, rst = 1'b1, sfr_hit;
	logic [7:0] pressed = 8'h00, port_one, sfr_rdata, keypad_pin_claim;
	sfr_req_s sfr_req = '0;
	keypad_status_s status;
	int n_errors = 0, num_checks = 0;
	key_matrix keys (.pressed(pressed), .port_one(port_one));
	keypad_level_interrupt dut (.ref_clk(ref_clk), .rst(rst), .port_one(port_one),
		.sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
		.keypad_pin_claim(keypad_pin_claim), .status(status));
	initial forever #2 ref_clk = ~ref_clk;
	initial #20000 report_and_stop(1);
	task report_and_stop(input int extra);
		n_errors += extra;
		if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task chk(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		n_errors += int'(g !== e);
		if (g !== e) $display("mismatch %0t %h %h", $time, g, e);
	endtask
	// read data stands only in the cycle after the strobe
	task bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
		@(negedge ref_clk);
		sfr_req <= '{!w, w, a, d};
		@(negedge ref_clk);
		sfr_req <= '0;
		if (!w) chk(sfr_rdata, e);
	endtask
	// six cycles cover synchroniser, flag and request stages
	task press(input logic [7:0] v);
		pressed = v;
		repeat (6) @(negedge ref_clk);
	endtask
	task t_lines;
		bus(1'b0, 8'h9e, 8'h00, 8'h00);
		bus(1'b1, 8'h9e, 8'h00, 8'h00);
		press(8'h24);
		press(8'h00);
		bus(1'b0, 8'h9e, 8'h00, 8'h24);
		bus(1'b0, 8'h9e, 8'h00, 8'h04);
		bus(1'b1, 8'h9e, 8'hfb, 8'h00);
		bus(1'b0, 8'h9e, 8'h00, 8'h00);
		bus(1'b1, 8'h9c, 8'h81, 8'h00);
		press(8'h00);
		bus(1'b0, 8'h9e, 8'h00, 8'h81);
		bus(1'b0, 8'h9e, 8'h00, 8'h81);
	endtask
	task t_core;
		bus(1'b1, 8'h9d, 8'h20, 8'h00);
		press(8'h20);
		chk({keypad_pin_claim[5:2], status}, 8'h84);
		bus(1'b1, 8'hb1, 8'h01, 8'h00);
		bus(1'b0, 8'hb1, 8'h00, 8'h01);
		chk({4'h0, status}, 8'h0c);
		bus(1'b1, 8'h9d, 8'h10, 8'h00);
		bus(1'b1, 8'hb1, 8'h00, 8'h00);
		chk({4'h0, status}, 8'h00);
		bus(1'b1, 8'hb2, 8'hff, 8'h00);
		bus(1'b1, 8'hb3, 8'hff, 8'h00);
		bus(1'b0, 8'hb3, 8'h00, 8'h01);
		chk({4'h0, status}, 8'h03);
		bus(1'b0, 8'h9f, 8'h00, 8'h00);
	endtask
	initial begin
		repeat (2) @(negedge ref_clk);
		rst = 1'b0;
		t_lines;
		t_core;
		report_and_stop(0);
	end
endmodule // keypad_level_interrupt_bench
